// *** rtl/pcp_pkg.sv ***
// Constants for the port configuration and Port 1 bus block
package pcp_pkg;

    // ---------------------------------------------------------------
    // Register indices
    // ---------------------------------------------------------------
    localparam logic [3:0] OFS_CFG   = 4'h0;
    localparam logic [3:0] OFS_P1DIR = 4'h1;
    localparam logic [3:0] OFS_P1OUT = 4'h2;
    localparam logic [3:0] OFS_P1CTL = 4'h3;
    localparam logic [3:0] OFS_P0OUT = 4'h4;
    localparam logic [3:0] OFS_P0DIR = 4'h5;
    localparam logic [3:0] OFS_P2M   = 4'h6;
    localparam logic [3:0] OFS_P3M   = 4'h7;
    localparam logic [3:0] OFS_P3OUT = 4'h8;
    localparam logic [3:0] OFS_XADL  = 4'h9;
    localparam logic [3:0] OFS_XADH  = 4'ha;
    localparam logic [3:0] OFS_XDAT  = 4'hb;
    localparam logic [3:0] OFS_XCMD  = 4'hc;
    localparam logic [3:0] OFS_P1IN  = 4'hd;
    localparam logic [3:0] OFS_P0IN  = 4'he;

    // ---------------------------------------------------------------
    // Field positions and reset values
    // ---------------------------------------------------------------
    localparam int CFG_CMP   = 0;
    localparam int CFG_P1PP  = 1;
    localparam int CFG_P0PP  = 2;
    localparam int CFG_P0STD = 3;
    localparam int CFG_P1STD = 4;
    localparam int CFG_P2STD = 5;
    localparam int CFG_P3STD = 6;
    localparam int CFG_OSC   = 7;
    localparam int CTL_UPPER = 2;
    localparam int CTL_FLOAT = 3;
    localparam int CMD_GO    = 0;
    localparam int CMD_RD    = 1;
    localparam logic [7:0] CFG_RST  = 8'hfe;
    localparam logic [7:0] DIR_RST  = 8'hff;
    localparam logic [7:0] ZERO8    = 8'h00;
    localparam logic [7:0] MODE_RST = 8'h00;

    // Port 1 modes
    localparam logic [1:0] P1_IO  = 2'h0;
    localparam logic [1:0] P1_HS  = 2'h1;
    localparam logic [1:0] P1_BUS = 2'h2;

    // Data strobe length in clock cycles
    localparam logic [2:0] DS_CYC = 3'h2;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ADDR = 2'b01,
        ST_DATA = 2'b10,
        ST_END  = 2'b11
    } pcp_st_e;

endpackage : pcp_pkg

// *** rtl/pcp_port_cfg.sv ***
// Port configuration, Port 1 I/O, handshake and external bus
//
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none

module pcp_port_cfg
    import pcp_pkg::*;
(
    input  wire logic       REF_CLK,
    input  wire logic       RESET,
    input  wire logic       STOP_WAKE,
    input  wire logic       INT_PROG_MEM,
    input  wire logic [3:0] ADDR,
    input  wire logic [7:0] WDATA,
    input  wire logic       WR,
    input  wire logic       RD,
    output logic      [7:0] RDATA,
    input  wire logic [7:0] P1_I,
    output logic      [7:0] P1_O,
    output logic      [7:0] P1_OE,
    input  wire logic [7:0] P0_I,
    output logic      [7:0] P0_O,
    output logic      [7:0] P0_OE,
    output logic            ADDR_STROBE_N_O,
    output logic            ADDR_STROBE_N_OE,
    output logic            DATA_STROBE_N_O,
    output logic            DATA_STROBE_N_OE,
    output logic            RD_WR_O,
    output logic            RD_WR_OE,
    input  wire logic       PORT3_LINE3,
    input  wire logic [1:0] CMP_IN,
    output logic      [3:0] P3_HI_O,
    output logic            P0_LOW_NOISE,
    output logic            P1_LOW_NOISE,
    output logic            P2_LOW_NOISE,
    output logic            P3_LOW_NOISE,
    output logic            OSC_LOW_DRIVE,
    output logic      [7:0] P2_MODE,
    output logic      [7:0] P3_MODE
);

    // ---------------------------------------------------------------
    // Register state
    // ---------------------------------------------------------------
    logic [7:0] port_drive_config_r;
    logic [7:0] p1_dir_r;
    logic [7:0] p1_out_r;
    logic [1:0] p1_mode_r;
    logic       upper_en_r;
    logic       float_r;
    logic [7:0] p0_out_r;
    logic [7:0] p0_dir_r;
    logic [7:0] port2_mode_reg_r;
    logic [7:0] port3_mode_reg_r;
    logic [3:0] p3_out_r;
    logic [7:0] xadl_r;
    logic [7:0] xadh_r;
    logic [7:0] xdat_r;
    logic       xrd_r;
    logic       hs_pend_r;
    logic [7:0] rdata_r;
    pcp_st_e    st_r;
    pcp_st_e    st_nxt;
    logic [2:0] ds_cnt_r;

    logic       clr;
    logic       wr_cfg;
    logic       wr_p1out;
    logic       wr_cmd;
    logic       busy;
    logic       hs_ready;
    logic       port1_data_avail_n;
    logic       bus_mode;

    // Stop wake-up clears like reset, except for the Port 2/3 modes
    assign clr      = RESET | STOP_WAKE;
    assign wr_cfg   = WR && (ADDR == OFS_CFG);
    assign wr_p1out = WR && (ADDR == OFS_P1OUT);
    assign wr_cmd   = WR && (ADDR == OFS_XCMD);
    assign busy     = (st_r != ST_IDLE);
    assign bus_mode = (p1_mode_r == P1_BUS);
    assign hs_ready = PORT3_LINE3;

    // ---------------------------------------------------------------
    // Drive configuration
    // ---------------------------------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (clr) begin
            port_drive_config_r <= CFG_RST;
        end else if (wr_cfg) begin
            port_drive_config_r <= WDATA;
        end
    end

    // Low-noise selects are the inverse of the standard-mode bits
    assign P0_LOW_NOISE  = ~port_drive_config_r[CFG_P0STD];
    assign P1_LOW_NOISE  = ~port_drive_config_r[CFG_P1STD];
    assign P2_LOW_NOISE  = ~port_drive_config_r[CFG_P2STD];
    assign P3_LOW_NOISE  = ~port_drive_config_r[CFG_P3STD];
    // Clock ratio is untouched; only oscillator drive drops
    assign OSC_LOW_DRIVE = ~port_drive_config_r[CFG_OSC];

    // ---------------------------------------------------------------
    // Port 1 mode and direction
    // ---------------------------------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (clr) begin
            p1_dir_r <= DIR_RST;
        end else if (WR && (ADDR == OFS_P1DIR)) begin
            p1_dir_r <= WDATA;
        end
    end

    // Without internal program memory the port wakes as the bus
    always_ff @(posedge REF_CLK) begin
        if (clr) begin
            p1_mode_r  <= INT_PROG_MEM ? P1_IO : P1_BUS;
            upper_en_r <= ~INT_PROG_MEM;
            float_r    <= 1'b0;
        end else if (WR && (ADDR == OFS_P1CTL)) begin
            p1_mode_r  <= WDATA[1:0];
            upper_en_r <= WDATA[CTL_UPPER];
            float_r    <= WDATA[CTL_FLOAT];
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (clr) begin
            p1_out_r <= ZERO8;
        end else if (wr_p1out) begin
            p1_out_r <= WDATA;
        end
    end

    // ---------------------------------------------------------------
    // Port 1 output handshake
    // ---------------------------------------------------------------
    // A new byte wins over an acknowledge in the same cycle
    always_ff @(posedge REF_CLK) begin
        if (clr) begin
            hs_pend_r <= 1'b0;
        end else if (wr_p1out && (p1_mode_r == P1_HS)) begin
            hs_pend_r <= 1'b1;
        end else if (hs_pend_r && hs_ready) begin
            hs_pend_r <= 1'b0;
        end
    end

    assign port1_data_avail_n = ~hs_pend_r;

    // ---------------------------------------------------------------
    // Port 0, Port 2/3 modes, Port 3 outputs
    // ---------------------------------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (clr) begin
            p0_out_r <= ZERO8;
            p0_dir_r <= DIR_RST;
            p3_out_r <= 4'h0;
        end else if (WR) begin
            if (ADDR == OFS_P0OUT) begin
                p0_out_r <= WDATA;
            end
            if (ADDR == OFS_P0DIR) begin
                p0_dir_r <= WDATA;
            end
            if (ADDR == OFS_P3OUT) begin
                p3_out_r <= WDATA[3:0];
            end
        end
    end

    // Only a true reset restores these; a stop wake-up keeps them
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            port2_mode_reg_r <= MODE_RST;
            port3_mode_reg_r <= MODE_RST;
        end else if (WR && (ADDR == OFS_P2M)) begin
            port2_mode_reg_r <= WDATA;
        end else if (WR && (ADDR == OFS_P3M)) begin
            port3_mode_reg_r <= WDATA;
        end
    end

    assign P2_MODE = port2_mode_reg_r;
    assign P3_MODE = port3_mode_reg_r;

    // Line 4 carries data-available in handshake mode unless the
    // comparator claims it
    always_comb begin
        P3_HI_O = p3_out_r;
        if (p1_mode_r == P1_HS) begin
            P3_HI_O[0] = port1_data_avail_n;
        end
        if (port_drive_config_r[CFG_CMP]) begin
            P3_HI_O[0] = CMP_IN[0];
            P3_HI_O[3] = CMP_IN[1];
        end
    end

    // ---------------------------------------------------------------
    // External bus cycle registers
    // ---------------------------------------------------------------
    // Address and write data are frozen while a cycle runs
    always_ff @(posedge REF_CLK) begin
        if (clr) begin
            xadl_r <= ZERO8;
            xadh_r <= ZERO8;
            xrd_r  <= 1'b0;
        end else if (WR && !busy) begin
            if (ADDR == OFS_XADL) begin
                xadl_r <= WDATA;
            end
            if (ADDR == OFS_XADH) begin
                xadh_r <= WDATA;
            end
            if (ADDR == OFS_XCMD) begin
                xrd_r <= WDATA[CMD_RD];
            end
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (clr) begin
            xdat_r <= ZERO8;
        end else if (st_r == ST_DATA && xrd_r && ds_cnt_r == 3'h1) begin
            xdat_r <= P1_I;
        end else if (WR && !busy && ADDR == OFS_XDAT) begin
            xdat_r <= WDATA;
        end
    end

    // ---------------------------------------------------------------
    // External bus sequencer
    // ---------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            ST_IDLE: begin
                if (wr_cmd && WDATA[CMD_GO] && bus_mode) begin
                    st_nxt = ST_ADDR;
                end
            end
            ST_ADDR: begin
                st_nxt = ST_DATA;
            end
            ST_DATA: begin
                if (ds_cnt_r == 3'h1) begin
                    st_nxt = ST_END;
                end
            end
            ST_END: begin
                st_nxt = ST_IDLE;
            end
            default: begin
                st_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge REF_CLK) begin
        if (clr) begin
            st_r <= ST_IDLE;
        end else begin
            st_r <= st_nxt;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (clr) begin
            ds_cnt_r <= 3'h0;
        end else if (st_r == ST_ADDR) begin
            ds_cnt_r <= DS_CYC;
        end else if (st_r == ST_DATA) begin
            ds_cnt_r <= ds_cnt_r - 3'h1;
        end
    end

    // Strobes follow the state; floated together with the ports
    assign ADDR_STROBE_N_O  = ~(st_r == ST_ADDR);
    assign DATA_STROBE_N_O  = ~(st_r == ST_DATA);
    assign RD_WR_O          = busy ? xrd_r : 1'b1;
    assign ADDR_STROBE_N_OE = bus_mode & ~float_r;
    assign DATA_STROBE_N_OE = bus_mode & ~float_r;
    assign RD_WR_OE         = bus_mode & ~float_r;

    // ---------------------------------------------------------------
    // Pin drivers
    // ---------------------------------------------------------------
    // Open-drain lines only drive a low; a high is left to the pull-up
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_pin
            logic p1_val;
            logic p1_drv;
            logic p0_val;
            logic p0_drv;

            always_comb begin
                p1_val = p1_out_r[gi];
                p1_drv = ~p1_dir_r[gi];
                if (bus_mode) begin
                    p1_drv = 1'b0;
                    if (st_r == ST_ADDR) begin
                        p1_val = xadl_r[gi];
                        p1_drv = 1'b1;
                    end else if (st_r == ST_DATA && !xrd_r) begin
                        p1_val = xdat_r[gi];
                        p1_drv = 1'b1;
                    end
                end
            end

            always_comb begin
                p0_val = p0_out_r[gi];
                p0_drv = ~p0_dir_r[gi];
                if (bus_mode && upper_en_r && busy) begin
                    p0_val = xadh_r[gi];
                    p0_drv = 1'b1;
                end
            end

            assign P1_O[gi]  = p1_val;
            assign P1_OE[gi] = p1_drv & ~float_r
                & (port_drive_config_r[CFG_P1PP] | ~p1_val);
            assign P0_O[gi]  = p0_val;
            assign P0_OE[gi] = p0_drv & ~float_r
                & (port_drive_config_r[CFG_P0PP] | ~p0_val);
        end
    endgenerate

    // ---------------------------------------------------------------
    // Read port
    // ---------------------------------------------------------------
    always_ff @(posedge REF_CLK) begin
        if (clr) begin
            rdata_r <= ZERO8;
        end else if (RD) begin
            case (ADDR)
                OFS_CFG:   rdata_r <= port_drive_config_r;
                OFS_P1DIR: rdata_r <= p1_dir_r;
                OFS_P1OUT: rdata_r <= p1_out_r;
                OFS_P1CTL: rdata_r <= {4'h0, float_r, upper_en_r,
                                       p1_mode_r};
                OFS_P0OUT: rdata_r <= p0_out_r;
                OFS_P0DIR: rdata_r <= p0_dir_r;
                OFS_P2M:   rdata_r <= port2_mode_reg_r;
                OFS_P3M:   rdata_r <= port3_mode_reg_r;
                OFS_P3OUT: rdata_r <= {4'h0, p3_out_r};
                OFS_XADL:  rdata_r <= xadl_r;
                OFS_XADH:  rdata_r <= xadh_r;
                OFS_XDAT:  rdata_r <= xdat_r;
                OFS_XCMD:  rdata_r <= {6'h00, hs_pend_r, busy};
                OFS_P1IN:  rdata_r <= P1_I;
                OFS_P0IN:  rdata_r <= P0_I;
                default:   rdata_r <= ZERO8;
            endcase
        end else begin
            rdata_r <= ZERO8;
        end
    end

    assign RDATA = rdata_r;

endmodule : pcp_port_cfg

`default_nettype wire

// *** tb/pcp_port_cfg_properties.sv ***
// Checker for the port configuration and Port 1 bus block
`timescale 1ns/1ns
`default_nettype none

module pcp_port_cfg_chk
    import pcp_pkg::*;
(
    input wire logic       REF_CLK,
    input wire logic       RESET,
    input wire logic       STOP_WAKE,
    input wire logic       INT_PROG_MEM,
    input wire logic [3:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic       WR,
    input wire logic [7:0] P1_O,
    input wire logic [7:0] P1_OE,
    input wire logic [7:0] P0_O,
    input wire logic [7:0] P0_OE,
    input wire logic       ADDR_STROBE_N_O,
    input wire logic       ADDR_STROBE_N_OE,
    input wire logic       DATA_STROBE_N_O,
    input wire logic       DATA_STROBE_N_OE,
    input wire logic       RD_WR_OE,
    input wire logic [1:0] CMP_IN,
    input wire logic [3:0] P3_HI_O,
    input wire logic       P0_LOW_NOISE,
    input wire logic       P1_LOW_NOISE,
    input wire logic       P2_LOW_NOISE,
    input wire logic       P3_LOW_NOISE,
    input wire logic       OSC_LOW_DRIVE,
    input wire logic [7:0] P2_MODE,
    input wire logic [7:0] P3_MODE
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RESET);

    // Config as software last wrote it, kept apart from the design's copy
    logic [7:0] cfg_q;
    always_ff @(posedge REF_CLK) begin
        if (RESET || STOP_WAKE) begin
            cfg_q <= CFG_RST;
        end else if (WR && ADDR == OFS_CFG) begin
            cfg_q <= WDATA;
        end
    end

    // ---------------------------------------------------------------
    // Configuration writes
    // ---------------------------------------------------------------
    property p_low_noise;
        WR && ADDR == OFS_CFG && !STOP_WAKE |=> {OSC_LOW_DRIVE, P3_LOW_NOISE,
            P2_LOW_NOISE, P1_LOW_NOISE, P0_LOW_NOISE} == ~$past(WDATA[7:3]);
    endproperty
    a_low_noise: assert property (p_low_noise)
        else $error("low-noise outputs do not follow the config write");
    property p_cmp_route;
        cfg_q[CFG_CMP] |->
            P3_HI_O[0] == CMP_IN[0] && P3_HI_O[3] == CMP_IN[1];
    endproperty
    a_cmp_route: assert property (p_cmp_route)
        else $error("comparator outputs not routed to port 3");
    property p_open_drain;
        !cfg_q[CFG_P1PP] |-> (P1_OE & P1_O) == 8'h00;
    endproperty
    a_open_drain: assert property (p_open_drain)
        else $error("open-drain line driven high");
    property p_open_drain_p0;
        !cfg_q[CFG_P0PP] |-> (P0_OE & P0_O) == 8'h00;
    endproperty
    a_open_drain_p0: assert property (p_open_drain_p0)
        else $error("port 0 open-drain line driven high");
    property p_float;
        WR && ADDR == OFS_P1CTL && WDATA[CTL_FLOAT] && !STOP_WAKE |=>
            P1_OE == 8'h00 && P0_OE == 8'h00 && !ADDR_STROBE_N_OE
            && !DATA_STROBE_N_OE && !RD_WR_OE;
    endproperty
    a_float: assert property (p_float)
        else $error("bus not floated");

    // ---------------------------------------------------------------
    // Bus cycle, reset and wake-up
    // ---------------------------------------------------------------
    property p_bus_cycle;
        $fell(ADDR_STROBE_N_O) && ADDR_STROBE_N_OE |-> (P1_OE | P1_O) == 8'hff
            ##1 (!DATA_STROBE_N_O)[*2] ##1 DATA_STROBE_N_O;
    endproperty
    a_bus_cycle: assert property (p_bus_cycle)
        else $error("bus cycle strobe sequence wrong");
    property p_as_pulse;
        $fell(ADDR_STROBE_N_O) |=> ADDR_STROBE_N_O;
    endproperty
    a_as_pulse: assert property (p_as_pulse)
        else $error("address strobe longer than one cycle");
    property p_prog_mem;
        $fell(RESET) && INT_PROG_MEM |-> P1_OE == 8'h00;
    endproperty
    a_prog_mem: assert property (p_prog_mem)
        else $error("port 1 not all input after reset");
    property p_stop_keep;
        STOP_WAKE && !WR |=> P2_MODE == $past(P2_MODE)
            && P3_MODE == $past(P3_MODE);
    endproperty
    a_stop_keep: assert property (p_stop_keep)
        else $error("mode registers lost on stop wake-up");
endmodule : pcp_port_cfg_chk
`default_nettype wire

// *** tb/pcp_mem_model.sv ***
// External memory model on the Port 1 multiplexed bus
`timescale 1ns/1ns
`default_nettype none

module pcp_mem_model
(
    input  wire logic       clk,
    input  wire logic       as_n,
    input  wire logic       ds_n,
    input  wire logic       rd_wr,
    input  wire logic [7:0] ad,
    output logic      [7:0] d_o,
    output logic            d_oe
);
    logic [7:0] mem [256];
    logic [7:0] addr_r;

    initial begin
        addr_r = 8'h00;
        for (int i = 0; i < 256; i++) begin
            mem[i] = ~8'(i);
        end
    end
    always @(posedge clk) begin
        if (!as_n) begin
            addr_r <= ad;
        end
        if (!ds_n && !rd_wr) begin
            mem[addr_r] <= ad;
        end
    end
    // Released lines show the pull-up, never stale read data
    assign d_oe = !ds_n && rd_wr;
    assign d_o  = d_oe ? mem[addr_r] : 8'hff;
endmodule : pcp_mem_model
`default_nettype wire

// *** tb/port_config_and_port1_bus_bench.sv ***
// Testbench for the port configuration and Port 1 bus block
`timescale 1ns/1ns
`default_nettype none

module port_config_and_port1_bus_bench
    import pcp_pkg::*;
;
    logic       ref_clk = 0, reset = 1, stop_wake = 0, int_prog_mem = 1;
    logic       wr = 0, rd = 0, port3_line3 = 0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic [1:0] cmp_in = 2'h2;
    logic [7:0] rdata, p1_o, p1_oe, p0_o, p0_oe, p2_mode, p3_mode, mem_d;
    logic [3:0] p3_hi_o;
    logic       as_n, as_oe, ds_n, ds_oe, rw, rw_oe, mem_oe;
    logic       ln0, ln1, ln2, ln3, osc;
    wire  [7:0] p1_pin = (p1_oe & p1_o) | (~p1_oe & (mem_oe ? mem_d : 8'hff));
    wire  [7:0] p0_pin = (p0_oe & p0_o) | ~p0_oe;
    int         n_mismatch = 0, samples_checked = 0, cyc = 0;

    always #5 ref_clk = ~ref_clk;

    pcp_port_cfg dut (.REF_CLK(ref_clk), .RESET(reset),
        .STOP_WAKE(stop_wake), .INT_PROG_MEM(int_prog_mem), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .P1_I(p1_pin),
        .P1_O(p1_o), .P1_OE(p1_oe), .P0_I(p0_pin), .P0_O(p0_o),
        .P0_OE(p0_oe), .ADDR_STROBE_N_O(as_n), .ADDR_STROBE_N_OE(as_oe),
        .DATA_STROBE_N_O(ds_n), .DATA_STROBE_N_OE(ds_oe), .RD_WR_O(rw),
        .RD_WR_OE(rw_oe), .PORT3_LINE3(port3_line3), .CMP_IN(cmp_in),
        .P3_HI_O(p3_hi_o), .P0_LOW_NOISE(ln0), .P1_LOW_NOISE(ln1),
        .P2_LOW_NOISE(ln2), .P3_LOW_NOISE(ln3), .OSC_LOW_DRIVE(osc),
        .P2_MODE(p2_mode), .P3_MODE(p3_mode));

    pcp_mem_model u_mem (.clk(ref_clk), .as_n(as_n | !as_oe),
        .ds_n(ds_n | !ds_oe), .rd_wr(rw | !rw_oe), .ad(p1_pin),
        .d_o(mem_d), .d_oe(mem_oe));

    // ---------------------------------------------------------------
    // Bus tasks and comparison
    // ---------------------------------------------------------------
    task automatic chk(input string nm, input logic [7:0] e,
                       input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic bus_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge ref_clk);
        wr <= 1'b0;
        #1;
    endtask : bus_wr
    task automatic bus_rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge ref_clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge ref_clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask : bus_rd
    task automatic wait_idle;
        logic [7:0] v;
        v = 8'h01;
        for (int i = 0; i < 20 && v[0] !== 1'b0; i++) bus_rd(OFS_XCMD, v);
        chk("busy", 8'h00, {7'h0, v[0]});
    endtask : wait_idle
    function automatic logic [7:0] noise();
        return {3'h0, osc, ln3, ln2, ln1, ln0};
    endfunction : noise

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic t_reset;
        logic [7:0] v;
        chk("p1 oe", 8'h00, p1_oe);
        bus_rd(OFS_CFG, v);
        chk("config", 8'hfe, v);
        chk("low noise", 8'h00, noise());
        bus_rd(4'hf, v);
        chk("unmapped", 8'h00, v);
        $display("reset test done");
    endtask : t_reset
    task automatic t_cfg;
        logic [7:0] v;
        bus_wr(OFS_CFG, 8'h01);
        chk("low noise", 8'h1f, noise());
        chk("p3 hi", 8'h08, {4'h0, p3_hi_o});
        @(posedge ref_clk);
        cmp_in <= 2'h1;
        @(posedge ref_clk);
        #1;
        chk("p3 hi", 8'h01, {4'h0, p3_hi_o});
        bus_rd(OFS_CFG, v);
        chk("config", 8'h01, v);
        bus_wr(OFS_P1DIR, 8'h00);
        bus_wr(OFS_P1OUT, 8'ha5);
        bus_wr(OFS_P0DIR, 8'h00);
        bus_wr(OFS_P0OUT, 8'h3c);
        chk("p1 oe od", 8'h5a, p1_oe);
        chk("p0 oe od", 8'hc3, p0_oe);
        bus_rd(OFS_P0IN, v);
        chk("p0 pins", 8'h3c, v);
        bus_wr(OFS_CFG, 8'hfe);
        chk("p1 oe pp", 8'hff, p1_oe);
        chk("p0 oe pp", 8'hff, p0_oe);
        chk("p3 hi", 8'h00, {4'h0, p3_hi_o});
        bus_wr(OFS_P1DIR, 8'hf0);
        chk("p1 oe dir", 8'h0f, p1_oe);
        chk("p1 out", 8'ha5, p1_o);
        bus_rd(OFS_P1IN, v);
        chk("p1 pins", 8'hf5, v);
        $display("config test done");
    endtask : t_cfg
    task automatic t_hs;
        logic [7:0] v;
        bus_wr(OFS_P1CTL, 8'h01);
        chk("data avail", 8'h01, {7'h0, p3_hi_o[0]});
        bus_wr(OFS_P1OUT, 8'h77);
        chk("data avail", 8'h00, {7'h0, p3_hi_o[0]});
        bus_rd(OFS_XCMD, v);
        chk("hs pending", 8'h02, v);
        @(posedge ref_clk);
        port3_line3 <= 1'b1;
        @(posedge ref_clk);
        port3_line3 <= 1'b0;
        @(posedge ref_clk);
        #1;
        chk("data avail", 8'h01, {7'h0, p3_hi_o[0]});
        $display("handshake test done");
    endtask : t_hs
    task automatic t_bus;
        logic [7:0] v;
        bus_wr(OFS_P1CTL, 8'h06);
        bus_wr(OFS_XADL, 8'h34);
        bus_wr(OFS_XADH, 8'h12);
        bus_wr(OFS_XDAT, 8'h5c);
        bus_wr(OFS_XCMD, 8'h01);
        chk("p0 upper", 8'h12, p0_o);
        wait_idle();
        chk("mem", 8'h5c, u_mem.mem[8'h34]);
        bus_wr(OFS_XADL, 8'h35);
        bus_wr(OFS_XCMD, 8'h03);
        wait_idle();
        bus_rd(OFS_XDAT, v);
        chk("bus read", 8'hca, v);
        $display("bus test done");
    endtask : t_bus
    task automatic t_float;
        chk("strobe oe", 8'h07, {5'h0, as_oe, ds_oe, rw_oe});
        bus_wr(OFS_P1CTL, 8'h0a);
        chk("strobe oe", 8'h00, {5'h0, as_oe, ds_oe, rw_oe});
        chk("p1 oe", 8'h00, p1_oe);
        chk("p0 oe", 8'h00, p0_oe);
        $display("float test done");
    endtask : t_float
    task automatic t_stop;
        bus_wr(OFS_P2M, 8'h3c);
        bus_wr(OFS_P3M, 8'h81);
        bus_wr(OFS_CFG, 8'h00);
        @(posedge ref_clk);
        stop_wake <= 1'b1;
        @(posedge ref_clk);
        stop_wake <= 1'b0;
        #1;
        chk("p2 mode", 8'h3c, p2_mode);
        chk("p3 mode", 8'h81, p3_mode);
        chk("low noise", 8'h00, noise());
        chk("p1 oe", 8'h00, p1_oe);
        $display("stop test done");
    endtask : t_stop

    // A true reset without internal program memory wakes Port 1 as the bus
    task automatic t_boot;
        logic [7:0] v;
        @(posedge ref_clk);
        int_prog_mem <= 1'b0;
        reset        <= 1'b1;
        repeat (2) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        #1;
        chk("p2 mode", 8'h00, p2_mode);
        chk("p1 oe", 8'h00, p1_oe);
        bus_rd(OFS_P1CTL, v);
        chk("p1 ctl", 8'h06, v);
        $display("boot test done");
    endtask : t_boot

    task automatic wrap_up;
        $display("compares %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up

    // A hang is cut short well past the expected run length
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            wrap_up();
        end
    end

    initial begin
        repeat (16) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        #1;
        t_reset();
        t_cfg();
        t_hs();
        t_bus();
        t_float();
        t_stop();
        t_boot();
        wrap_up();
    end
endmodule : port_config_and_port1_bus_bench

bind pcp_port_cfg pcp_port_cfg_chk u_chk (.REF_CLK(REF_CLK), .RESET(RESET),
    .STOP_WAKE(STOP_WAKE), .INT_PROG_MEM(INT_PROG_MEM), .ADDR(ADDR),
    .WDATA(WDATA), .WR(WR), .P1_O(P1_O), .P1_OE(P1_OE), .P0_O(P0_O),
    .P0_OE(P0_OE), .ADDR_STROBE_N_O(ADDR_STROBE_N_O),
    .ADDR_STROBE_N_OE(ADDR_STROBE_N_OE), .DATA_STROBE_N_O(DATA_STROBE_N_O),
    .DATA_STROBE_N_OE(DATA_STROBE_N_OE), .RD_WR_OE(RD_WR_OE),
    .CMP_IN(CMP_IN), .P3_HI_O(P3_HI_O), .P0_LOW_NOISE(P0_LOW_NOISE),
    .P1_LOW_NOISE(P1_LOW_NOISE), .P2_LOW_NOISE(P2_LOW_NOISE),
    .P3_LOW_NOISE(P3_LOW_NOISE), .OSC_LOW_DRIVE(OSC_LOW_DRIVE),
    .P2_MODE(P2_MODE), .P3_MODE(P3_MODE));
`default_nettype wire
